// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import abmc_pkg::*;
  logic       i_clk         = 1'b0;
  logic       i_rst         = 1'b1;
  logic       i_ext_clk_src = 1'b0;
  logic       i_wr_en       = 1'b0;
  logic       i_rd_en       = 1'b0;
  logic [3:0] i_addr        = 4'h0;
  logic [7:0] i_wdata       = 8'h00;
  logic [7:0] o_rdata;
  logic       o_rd_valid;
  logic       o_clock_source_flag;
  abmc_ctrl_s o_ctrl;
  int         err_total     = 0;
  int         num_checks    = 0;

  always #25 i_clk = ~i_clk;

  abmc_regs abmc_regs_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_ext_clk_src(i_ext_clk_src),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .o_clock_source_flag(o_clock_source_flag), .o_ctrl(o_ctrl)
  );

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_ctrl(input abmc_ctrl_s got, input abmc_ctrl_s exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes change at the falling edge and are taken at the next rising edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_wr_en = 1'b1;
    i_addr  = a;
    i_wdata = d;
    @(negedge i_clk);
    i_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_rd_en = 1'b1;
    i_addr  = a;
    @(negedge i_clk);
    i_rd_en = 1'b0;
    cmp8({7'h00, o_rd_valid}, 8'h01);
    cmp8(o_rdata, e);
  endtask

  // A read on the edge right after a write must already see the written value.
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge i_clk);
    i_wr_en = 1'b1;
    i_addr  = a;
    i_wdata = d;
    @(negedge i_clk);
    i_wr_en = 1'b0;
    i_rd_en = 1'b1;
    @(negedge i_clk);
    i_rd_en = 1'b0;
    cmp8({7'h00, o_rd_valid}, 8'h01);
    cmp8(o_rdata, e);
  endtask

  task automatic t_reset;
    rd(ABMC_ADDR_BIAS, 8'h00);
    rd(ABMC_ADDR_MUX, 8'h00);
    rd(ABMC_ADDR_SYS, 8'h00);
    rd(4'h0, 8'h00);
    cmp_ctrl(o_ctrl, CTRL_RESET);
    wr(4'h0, 8'hFF);
    cmp_ctrl(o_ctrl, CTRL_RESET);
  endtask

  task automatic t_bias;
    wr(ABMC_ADDR_BIAS, 8'hFE);
    cmp_ctrl(o_ctrl, '{ROUTE_NORMAL, 1'b0, 1'b1, 3'h0, 4'h0});
    wr(ABMC_ADDR_BIAS, 8'h01);
    cmp_ctrl(o_ctrl, '{ROUTE_NORMAL, 1'b1, 1'b0, 3'h0, 4'h0});
    wr_rd(ABMC_ADDR_BIAS, 8'hFF, 8'h03);
  endtask

  task automatic msel(input logic [2:0] s, input abmc_route_e r, input logic [2:0] g,
                      input logic b);
    wr(ABMC_ADDR_MUX, {5'h1F, s});
    cmp_ctrl(o_ctrl, '{r, b, b, g, 4'h7});
    rd(ABMC_ADDR_MUX, {5'h00, s});
  endtask

  task automatic t_mux;
    wr(ABMC_ADDR_SYS, 8'h57);
    msel(3'h1, ROUTE_MID_SUPPLY, 3'h5, 1'b0);
    msel(3'h2, ROUTE_REFERENCE, 3'h0, 1'b0);
    msel(3'h3, ROUTE_TEMP_DIODE, 3'h0, 1'b0);
    msel(3'h1, ROUTE_MID_SUPPLY, 3'h5, 1'b0);
    msel(3'h4, ROUTE_NORMAL, 3'h5, 1'b0);
    msel(3'h0, ROUTE_NORMAL, 3'h5, 1'b1);
    rd(ABMC_ADDR_SYS, 8'h57);
  endtask

  task automatic t_sys;
    wr(ABMC_ADDR_SYS, 8'hFF);
    cmp_ctrl(o_ctrl, '{ROUTE_NORMAL, 1'b1, 1'b1, 3'h7, 4'h9});
    rd(ABMC_ADDR_SYS, 8'h7F);
    wr(ABMC_ADDR_SYS, 8'h80);
    cmp_ctrl(o_ctrl, '{ROUTE_NORMAL, 1'b1, 1'b1, 3'h0, 4'h0});
  endtask

  task automatic t_clk;
    i_ext_clk_src = 1'b1;
    repeat (3) @(negedge i_clk);
    cmp8({7'h00, o_clock_source_flag}, 8'h01);
    wr(ABMC_ADDR_MUX, 8'h7A);
    rd(ABMC_ADDR_MUX, 8'h82);
    i_ext_clk_src = 1'b0;
    repeat (3) @(negedge i_clk);
    rd(ABMC_ADDR_MUX, 8'h02);
  endtask

  task automatic test_done;
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    t_reset;
    t_bias;
    t_mux;
    t_sys;
    t_clk;
    test_done;
  end

  // The tests need well under 200 cycles, so 2000 cycles means a hang.
  initial begin
    #(50 * 2000);
    err_total++;
    test_done;
  end
endmodule

// ==== hw/abmc_pkg.sv ====
package abmc_pkg;

  localparam logic [3:0] ABMC_ADDR_BIAS = 4'h1;
  localparam logic [3:0] ABMC_ADDR_MUX  = 4'h2;
  localparam logic [3:0] ABMC_ADDR_SYS  = 4'h3;

  localparam int BIAS_NEG_BIT   = 1;
  localparam int BIAS_POS_BIT   = 0;
  localparam int MUX_CLK_BIT    = 7;
  localparam int MUX_SEL_LSB    = 0;
  localparam int SYS_GAIN_LSB   = 4;
  localparam int SYS_RATE_LSB   = 0;

  localparam logic [1:0] BIAS_RESET = 2'h0;
  localparam logic [2:0] SEL_RESET  = 3'h0;
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [3:0] RATE_RESET = 4'h0;

  localparam logic [2:0] SEL_NORMAL = 3'h0;
  localparam logic [2:0] SEL_OFFSET = 3'h1;
  localparam logic [2:0] SEL_GAIN   = 3'h2;
  localparam logic [2:0] SEL_TEMP   = 3'h3;
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  localparam logic [3:0] RATE_TOP   = 4'h9;

  typedef enum logic [1:0] {
    ROUTE_NORMAL,
    ROUTE_MID_SUPPLY,
    ROUTE_REFERENCE,
    ROUTE_TEMP_DIODE
  } abmc_route_e;

  typedef struct packed {
    abmc_route_e route;
    logic        bias_pos;
    logic        bias_neg;
    logic [2:0]  gain;
    logic [3:0]  rate;
  } abmc_ctrl_s;

  typedef struct packed {
    logic [1:0] bias;
    logic [2:0] sel;
    logic [2:0] gain;
    logic [3:0] rate;
    logic       clk_meta;
    logic       clk_sync;
    logic [7:0] rdata;
    logic       rd_valid;
    abmc_ctrl_s ctrl;
  } abmc_state_s;

  localparam abmc_ctrl_s CTRL_RESET = '{ROUTE_NORMAL, 1'b0, 1'b0, 3'h0, 4'h0};

endpackage

// ==== hw/abmc_regs.sv ====
`timescale 1ns/100ps
// What this block does
// - Bias register resets to zero; upper six bits read as zero.
// - Bias bit 1 ties the negative input to mid-supply when set.
// - Bias bit 0 ties the positive input to mid-supply when set.
// - Monitor register at 02h: bit 7 status, bits 6..3 zero, bits 2..0 selector.
// - Bit 7 reads 0 on internal oscillator, 1 on external clock.
// - Selector resets to 000, normal path with stored gain.
// - A nonzero selector overrides the bias enables.
// - Selector 001 ties both converter inputs to mid-supply, stored gain kept.
// - Selector 010 connects the reference across the inputs, gain forced to 1.
// - Selector 011 routes to the temperature diode, gain forced to 1.
// - Forced gain never overwrites the stored gain field.
// - Gain and rate register at 03h resets 00h; bit 7 reads zero.
// - Gain code selects powers of two, 000 is gain 1 by default.
// - Rate code 0000 is default; codes 1001 to 1111 act as the top rate.
module abmc_regs
  import abmc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ext_clk_src,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rd_valid,
  output logic            o_clock_source_flag,
  output abmc_ctrl_s      o_ctrl
);

  abmc_state_s st;
  abmc_state_s next_st;

  always_comb begin
    next_st          = st;
    next_st.clk_meta = i_ext_clk_src;
    next_st.clk_sync = st.clk_meta;
    next_st.rd_valid = i_rd_en;
    if (i_wr_en) begin
      case (i_addr)
        ABMC_ADDR_BIAS: begin
          next_st.bias = i_wdata[BIAS_NEG_BIT:BIAS_POS_BIT];
        end
        ABMC_ADDR_MUX: begin
          next_st.sel = i_wdata[MUX_SEL_LSB +: 3];
        end
        ABMC_ADDR_SYS: begin
          next_st.gain = i_wdata[SYS_GAIN_LSB +: 3];
          next_st.rate = i_wdata[SYS_RATE_LSB +: 4];
        end
        default: begin
          next_st.rate = next_st.rate;
        end
      endcase
    end
    if (i_rd_en) begin
      case (i_addr)
        ABMC_ADDR_BIAS: next_st.rdata = {6'h00, st.bias};
        ABMC_ADDR_MUX:  next_st.rdata = {st.clk_sync, 4'h0, st.sel};
        ABMC_ADDR_SYS:  next_st.rdata = {1'b0, st.gain, st.rate};
        default:        next_st.rdata = 8'h00;
      endcase
    end
    next_st.ctrl.bias_pos = next_st.bias[BIAS_POS_BIT]
                            && (next_st.sel == SEL_NORMAL);
    next_st.ctrl.bias_neg = next_st.bias[BIAS_NEG_BIT]
                            && (next_st.sel == SEL_NORMAL);
    next_st.ctrl.gain     = next_st.gain;
    next_st.ctrl.route    = ROUTE_NORMAL;
    case (next_st.sel)
      SEL_OFFSET: begin
        next_st.ctrl.route = ROUTE_MID_SUPPLY;
      end
      SEL_GAIN: begin
        next_st.ctrl.route = ROUTE_REFERENCE;
        next_st.ctrl.gain  = GAIN_UNITY;
      end
      SEL_TEMP: begin
        next_st.ctrl.route = ROUTE_TEMP_DIODE;
        next_st.ctrl.gain  = GAIN_UNITY;
      end
      default: begin
        next_st.ctrl.route = ROUTE_NORMAL;
      end
    endcase
    next_st.ctrl.rate = (next_st.rate > RATE_TOP) ? RATE_TOP : next_st.rate;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st.bias     <= BIAS_RESET;
      st.sel      <= SEL_RESET;
      st.gain     <= GAIN_RESET;
      st.rate     <= RATE_RESET;
      st.clk_meta <= 1'b0;
      st.clk_sync <= 1'b0;
      st.rdata    <= 8'h00;
      st.rd_valid <= 1'b0;
      st.ctrl     <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata             = st.rdata;
  assign o_rd_valid          = st.rd_valid;
  assign o_clock_source_flag = st.clk_sync;
  assign o_ctrl              = st.ctrl;

  a_bias_read_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && i_addr == ABMC_ADDR_BIAS) |=> (o_rd_valid && o_rdata[7:2] == 6'h00))
    else $error("Bias register upper bits not zero on read.");

  a_neg_bias_on: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && i_addr == ABMC_ADDR_BIAS && i_wdata[1] && st.sel == SEL_NORMAL)
      |=> o_ctrl.bias_neg)
    else $error("Negative input bias not applied after write.");

  a_pos_bias_on: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && i_addr == ABMC_ADDR_BIAS && i_wdata[0] && st.sel == SEL_NORMAL)
      |=> o_ctrl.bias_pos)
    else $error("Positive input bias not applied after write.");

  a_mux_read_fields: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && i_addr == ABMC_ADDR_MUX && !i_wr_en)
      |=> (o_rdata[6:3] == 4'h0 && o_rdata[7] == $past(o_clock_source_flag)
           && o_rdata[2:0] == $past(st.sel)))
    else $error("Monitor register read back wrong.");

  a_clk_flag_follow: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_ext_clk_src [*3] |-> o_clock_source_flag)
    else $error("Clock source flag does not follow the clock source.");

  a_normal_gain: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st.sel == SEL_NORMAL) |-> (o_ctrl.route == ROUTE_NORMAL && o_ctrl.gain == st.gain))
    else $error("Normal path does not use the stored gain.");

  a_monitor_bias_off: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st.sel != SEL_NORMAL) |-> (!o_ctrl.bias_pos && !o_ctrl.bias_neg))
    else $error("Bias enable active while a monitor is selected.");

  a_offset_route: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && i_addr == ABMC_ADDR_MUX && i_wdata[2:0] == SEL_OFFSET)
      |=> (o_ctrl.route == ROUTE_MID_SUPPLY && o_ctrl.gain == st.gain))
    else $error("Offset selection did not tie inputs to mid-supply.");

  a_ref_gain_unity: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st.sel == SEL_GAIN) |-> (o_ctrl.route == ROUTE_REFERENCE && o_ctrl.gain == GAIN_UNITY))
    else $error("Reference selection did not force unity gain.");

  a_temp_gain_unity: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st.sel == SEL_TEMP) |-> (o_ctrl.route == ROUTE_TEMP_DIODE && o_ctrl.gain == GAIN_UNITY))
    else $error("Temperature selection did not force unity gain.");

  a_gain_kept: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && i_addr == ABMC_ADDR_MUX) |=> (st.gain == $past(st.gain)))
    else $error("Stored gain changed by a monitor selection.");

  a_sys_read_top: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd_en && i_addr == ABMC_ADDR_SYS) |=> (o_rdata[7] == 1'b0))
    else $error("Gain and rate register bit 7 not zero.");

  a_rate_clamp: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (st.rate > RATE_TOP) |-> (o_ctrl.rate == RATE_TOP))
    else $error("Rate codes above nine not mapped to the top rate.");

  a_bias_write_mask: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr_en && i_addr == ABMC_ADDR_BIAS) ##1 (i_rd_en && i_addr == ABMC_ADDR_BIAS && !i_wr_en)
      |=> (o_rdata == {6'h00, $past(i_wdata[1:0], 2)}))
    else $error("Bias write did not ignore reserved bits.");

endmodule
